// >>> include/hbp_pkg.sv
// Shared types and constants of the parallel host bus port.
package hbp_pkg;
  localparam logic [15:0] HBP_CORE_LIMIT = 16'h2000;
  localparam logic [1:0] HBP_BE_BOTH = 2'h3;
  localparam logic [1:0] HBP_BE_LO = 2'h1;
  localparam logic [1:0] HBP_BE_HI = 2'h2;
  localparam logic [7:0] HBP_BYTE_RST = 8'h00;
  localparam logic [15:0] HBP_WORD_RST = 16'h0000;

  // Polarity bits are 1 for an active-high pin.
  typedef struct packed {
    logic rw_mode;
    logic rw_pol;
    logic en_pol;
    logic rd_pol;
    logic wr_pol;
    logic cs_pol;
    logic ale_pol;
    logic be_pol;
    logic hold_pol;
    logic ale_qual;
    logic dual_phase;
    logic bus16;
    logic indexed;
    logic posted;
  } hbp_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0] be;
  } hbp_req_t;

  typedef struct packed {
    logic cs_q;
    logic rd_q;
    logic wr_q;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic pending;
    logic issued;
    logic rdone;
    logic np_done;
    logic hold_act;
    hbp_req_t req;
    logic [15:0] rdata;
    logic [7:0] lo_o;
    logic lo_oe;
    logic [7:0] hi_o;
    logic hi_oe;
    logic hold_o;
    logic hold_oe;
  } hbp_st_t;

  localparam hbp_st_t HBP_ST_RST = '0;
endpackage : hbp_pkg

// >>> core/hbp_port.sv
// Slave side of the multiplexed 8/16-bit host bus port.
`timescale 1ns/1ps
`default_nettype none

module hbp_port
  import hbp_pkg::*;
#(
  parameter logic [15:0] CORE_LIMIT = HBP_CORE_LIMIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire hbp_cfg_t cfg,
  input wire logic device_select,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic high_addr_latch_strobe,
  input wire logic low_addr_latch_strobe,
  input wire logic [1:0] byte_lane_enables,
  input wire logic big_endian,
  input wire logic [7:0] ad_lo_in,
  input wire logic [7:0] d_hi_in,
  output logic [7:0] ad_lo_out,
  output logic ad_lo_oe,
  output logic [7:0] d_hi_out,
  output logic d_hi_oe,
  output logic hold_out,
  output logic hold_oe,
  output hbp_req_t int_req,
  input wire logic int_ack,
  input wire logic [15:0] int_rdata
);

  function automatic logic is_core(input logic [15:0] a);
    is_core = a < CORE_LIMIT;
  endfunction : is_core

  function automatic logic [15:0] swap16(input logic [15:0] v,
                                        input logic sw);
    swap16 = sw ? {v[7:0], v[15:8]} : v;
  endfunction : swap16

  hbp_st_t st_ff;
  hbp_st_t nxt_st;

  logic cs_a;
  logic rd_a;
  logic wr_a;
  logic high_addr_latch_strobe_a;
  logic low_addr_latch_strobe_a;
  logic ale_ok;
  logic [1:0] be_a;
  logic wide;
  logic swap;
  logic [15:0] addr;
  logic wr_rise;
  logic wr_fall;
  logic [15:0] wdata;
  logic [1:0] wbe;
  logic [15:0] rview;

  always_comb begin
    cs_a = device_select == cfg.cs_pol;
    if (cfg.rw_mode) begin
      rd_a = (transfer_en()) && (read_strobe != cfg.rw_pol);
      wr_a = (transfer_en()) && (read_strobe == cfg.rw_pol);
    end else begin
      rd_a = read_strobe == cfg.rd_pol;
      wr_a = write_strobe == cfg.wr_pol;
    end
    be_a = cfg.be_pol ? byte_lane_enables : ~byte_lane_enables;
    ale_ok = !cfg.ale_qual || cs_a;
    high_addr_latch_strobe_a = (high_addr_latch_strobe == cfg.ale_pol) && ale_ok;
    low_addr_latch_strobe_a = (low_addr_latch_strobe == cfg.ale_pol) && ale_ok;
    wide = cfg.bus16 && !cfg.indexed;
    swap = wide && big_endian;
    addr = {st_ff.addr_hi, st_ff.addr_lo};
    wr_rise = wr_a && !st_ff.wr_q;
    wr_fall = st_ff.wr_q && !wr_a;
  end

  // The select-plus-enable scheme shares the write strobe pin as enable.
  function automatic logic transfer_en();
    transfer_en = write_strobe == cfg.en_pol;
  endfunction : transfer_en

  // Lane steering for writes; only the low shared lines carry 8-bit data.
  always_comb begin
    if (wide) begin
      wdata = swap16({d_hi_in, ad_lo_in}, swap);
      wbe = is_core(addr) ? be_a : HBP_BE_BOTH;
      if (swap) begin
        wbe = {wbe[0], wbe[1]};
      end
    end else begin
      wdata = {ad_lo_in, ad_lo_in};
      wbe = addr[0] ? HBP_BE_HI : HBP_BE_LO;
    end
  end

  assign rview = swap16(st_ff.rdata, swap);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cs_q = cs_a;
    nxt_st.rd_q = rd_a;
    nxt_st.wr_q = wr_a;

    if (cfg.dual_phase) begin
      // Either phase may come first or be skipped.
      if (high_addr_latch_strobe_a) begin
        nxt_st.addr_hi = ad_lo_in;
      end
      if (low_addr_latch_strobe_a) begin
        nxt_st.addr_lo = ad_lo_in;
      end
    end else if (low_addr_latch_strobe_a) begin
      nxt_st.addr_hi = d_hi_in;
      nxt_st.addr_lo = ad_lo_in;
    end

    // The internal side keeps one request; ack retires it.
    if (st_ff.req.valid && int_ack) begin
      nxt_st.req.valid = 1'b0;
      if (st_ff.req.write) begin
        nxt_st.pending = 1'b0;
        nxt_st.np_done = st_ff.wr_q;
      end else begin
        nxt_st.rdata = int_rdata;
        nxt_st.rdone = 1'b1;
      end
    end

    if (rd_a && cs_a) begin
      if (!st_ff.issued && !st_ff.pending && !st_ff.req.valid) begin
        nxt_st.issued = 1'b1;
        nxt_st.req = '{valid: 1'b1, write: 1'b0, addr: addr,
                       data: HBP_WORD_RST, be: wbe};
      end
    end else if (!rd_a) begin
      nxt_st.issued = 1'b0;
      nxt_st.rdone = 1'b0;
    end

    if (cs_a && (cfg.posted || cfg.indexed)) begin
      if (wr_fall && !st_ff.req.valid) begin
        nxt_st.pending = 1'b1;
        nxt_st.req = '{valid: 1'b1, write: 1'b1, addr: addr,
                       data: wdata, be: wbe};
      end
    end else if (cs_a) begin
      if (wr_rise && is_core(addr) && !st_ff.req.valid) begin
        // Core space and process RAM take the write while strobe active.
        nxt_st.req = '{valid: 1'b1, write: 1'b1, addr: addr,
                       data: wdata, be: wbe};
      end else if (wr_rise) begin
        // Other registers commit at strobe end, so release early.
        nxt_st.np_done = 1'b1;
      end
      if (wr_fall && !is_core(addr) && !st_ff.req.valid) begin
        nxt_st.req = '{valid: 1'b1, write: 1'b1, addr: addr,
                       data: wdata, be: wbe};
      end
    end
    if (!wr_a && !wr_fall) begin
      nxt_st.np_done = 1'b0;
    end

    // Hold stays active until internal work for this cycle is done; a non-posted write outside core space releases it at strobe start.
    nxt_st.hold_act = st_ff.pending || nxt_st.pending
      || (rd_a && !st_ff.rdone)
      || (wr_a && !cfg.posted && !cfg.indexed
          && !st_ff.np_done);
    nxt_st.hold_oe = cs_a;
    nxt_st.hold_o = nxt_st.hold_act ? cfg.hold_pol : !cfg.hold_pol;

    nxt_st.lo_oe = cs_a && rd_a;
    nxt_st.hi_oe = cs_a && rd_a && wide;
    if (wide) begin
      nxt_st.lo_o = rview[7:0];
      nxt_st.hi_o = rview[15:8];
    end else begin
      nxt_st.lo_o = addr[0] ? st_ff.rdata[15:8] : st_ff.rdata[7:0];
      nxt_st.hi_o = HBP_BYTE_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= HBP_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ad_lo_out = st_ff.lo_o;
  assign ad_lo_oe = st_ff.lo_oe;
  assign d_hi_out = st_ff.hi_o;
  assign d_hi_oe = st_ff.hi_oe;
  assign hold_out = st_ff.hold_o;
  assign hold_oe = st_ff.hold_oe;
  assign int_req = st_ff.req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sel_hold;
    $rose(cs_a) && st_ff.pending |=> hold_oe && st_ff.hold_act;
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("hold not active on select with pending write");

  property p_rd_hold;
    cs_a && rd_a && !st_ff.rdone |=> hold_oe && st_ff.hold_act;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("hold not active during read fetch");

  // Both lanes must be driven for a wide read, or the host reads a floating
  // upper byte.
  property p_wide_oe;
    cs_a && rd_a && wide |=> d_hi_oe && ad_lo_oe;
  endproperty
  a_wide_oe: assert property (p_wide_oe)
    else $error("wide read lanes not driven");

  property p_narrow;
    !wide |=> !d_hi_oe;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("upper data pins driven in 8-bit mode");

  property p_ale_qual;
    cfg.ale_qual && !cs_a && cfg.dual_phase |=> $stable(st_ff.addr_hi);
  endproperty
  a_ale_qual: assert property (p_ale_qual)
    else $error("address latched without device select");

  property p_post_pend;
    cs_a && cfg.posted && wr_fall && !st_ff.req.valid |=>
      st_ff.pending && int_req.valid && int_req.write;
  endproperty
  a_post_pend: assert property (p_post_pend)
    else $error("posted write not issued at strobe end");

  property p_post_data;
    cs_a && cfg.posted && wide && !big_endian && wr_fall
      && !st_ff.req.valid |=> int_req.data == $past({d_hi_in, ad_lo_in});
  endproperty
  a_post_data: assert property (p_post_data)
    else $error("posted write data not taken at strobe end");

  property p_np_hold;
    cs_a && !cfg.posted && !cfg.indexed && wr_rise |=> st_ff.hold_act;
  endproperty
  a_np_hold: assert property (p_np_hold)
    else $error("non-posted write did not assert hold");

  property p_be_ignored;
    int_req.valid && int_req.write && wide && !is_core(int_req.addr)
      |-> int_req.be == HBP_BE_BOTH;
  endproperty
  a_be_ignored: assert property (p_be_ignored)
    else $error("byte enables used outside core space");

  property p_rd_release;
    $fell(st_ff.hold_act) && st_ff.rd_q && !cfg.posted |-> st_ff.rdone;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("hold released before read data fetched");

  c_read: cover property (cs_a && rd_a ##[1:20] st_ff.rdone);
  c_posted: cover property (cfg.posted && wr_fall ##[1:20] !st_ff.pending);
  c_np_core: cover property (!cfg.posted && wr_rise && is_core(addr));
  c_swap: cover property (swap && int_req.valid);

endmodule : hbp_port

`default_nettype wire

// >>> bench/hbp_host.sv
// Behavioural host bus master for the multiplexed port pins.
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  input wire logic clk,
  input wire logic hold_out,
  input wire logic hold_oe,
  input wire logic [7:0] ad_in,
  input wire logic [7:0] dh_in,
  output logic cs,
  output logic rd,
  output logic wr,
  output logic ahi,
  output logic alo,
  output logic [7:0] ad,
  output logic [7:0] dh
);
  initial begin
    {cs, rd, wr, ahi, alo} = 5'h00;
    ad = 8'h00;
    dh = 8'h00;
  end
  task automatic sel(input logic on);
    @(negedge clk);
    cs = on;
  endtask : sel
  task automatic latch(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge clk);
    alo = 1'b1;
    ad = lo;
    @(negedge clk);
    alo = 1'b0;
    ahi = 1'b1;
    ad = hi;
    @(negedge clk);
    ahi = 1'b0;
  endtask : latch
  // A release only counts once the hold has been seen active first.
  task automatic wait_hold(output logic ok);
    logic seen;
    seen = 1'b0;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(negedge clk);
      if (hold_out === 1'b1) seen = 1'b1;
      else if (seen && hold_oe === 1'b1) ok = 1'b1;
    end
  endtask : wait_hold
  task automatic do_rd(output logic [15:0] v, output logic ok);
    @(negedge clk);
    rd = 1'b1;
    ad = ~ad;
    wait_hold(ok);
    @(negedge clk);
    v = {dh_in, ad_in};
    @(negedge clk);
    rd = 1'b0;
  endtask : do_rd
  task automatic do_wr(input logic [15:0] v, input logic posted,
                       output logic ok);
    @(negedge clk);
    ad = v[7:0];
    dh = v[15:8];
    wr = 1'b1;
    if (posted) begin
      @(negedge clk);
      wr = 1'b0;
    end
    wait_hold(ok);
    @(negedge clk);
    wr = 1'b0;
  endtask : do_wr
endmodule : hbp_host
`default_nettype wire

// >>> bench/parallel_host_bus_port_bench.sv
// Self-checking bench for the multiplexed host bus port.
`timescale 1ns/1ps
`default_nettype none
module parallel_host_bus_port_bench;
  import hbp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic big_endian = 1'b0;
  logic int_ack = 1'b0;
  logic [15:0] int_rdata = 16'h0000;
  logic [1:0] be_pins = 2'h3;
  hbp_cfg_t cfg = '0;
  hbp_req_t int_req, cap;
  logic cs, rd, wr, ahi, alo, ad_lo_oe, d_hi_oe, hold_out, hold_oe;
  logic [7:0] h_ad, h_dh, ad_lo_out, d_hi_out;
  int mismatches = 0, num_checks = 0, cyc = 0, n_acks = 0;
  wire logic [7:0] ad_in = ad_lo_oe ? ad_lo_out : h_ad;
  wire logic [7:0] dh_in = d_hi_oe ? d_hi_out : h_dh;
  always #5 clk = ~clk;
  hbp_port uut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .device_select(cs),
    .read_strobe(rd), .write_strobe(wr), .high_addr_latch_strobe(ahi),
    .low_addr_latch_strobe(alo), .byte_lane_enables(be_pins),
    .big_endian(big_endian), .ad_lo_in(ad_in), .d_hi_in(dh_in),
    .ad_lo_out(ad_lo_out), .ad_lo_oe(ad_lo_oe), .d_hi_out(d_hi_out),
    .d_hi_oe(d_hi_oe), .hold_out(hold_out), .hold_oe(hold_oe),
    .int_req(int_req), .int_ack(int_ack), .int_rdata(int_rdata));
  hbp_host h (.clk(clk), .hold_out(hold_out), .hold_oe(hold_oe),
    .ad_in(ad_in), .dh_in(dh_in), .cs(cs), .rd(rd), .wr(wr), .ahi(ahi),
    .alo(alo), .ad(h_ad), .dh(h_dh));
  // The internal side answers after a random delay to stretch the hold.
  always @(negedge clk) begin
    int_ack <= 1'b0;
    if (int_req.valid === 1'b1 && !int_ack && $urandom_range(2) == 0) begin
      int_ack <= 1'b1;
      int_rdata <= 16'($urandom);
      cap <= int_req;
      n_acks <= n_acks + 1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  function automatic logic [15:0] swap(input logic [15:0] v, input logic b);
    return b ? {v[7:0], v[15:8]} : v;
  endfunction : swap
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    chk16({15'h0, g}, {15'h0, e});
  endtask : chk1
  task automatic chk_req(input hbp_req_t g, input hbp_req_t e);
    chk16(g.addr, e.addr);
    chk16({14'h0, g.be}, {14'h0, e.be});
    chk1(g.write, e.write);
    if (e.write) chk16(g.data, e.data);
  endtask : chk_req
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    logic [7:0] hi, lo;
    logic [15:0] v, e;
    logic ok;
    int n;
    hbp_req_t x;
    void'($urandom(25));
    {cfg.en_pol, cfg.rd_pol, cfg.wr_pol, cfg.cs_pol} = 4'hf;
    {cfg.ale_pol, cfg.be_pol, cfg.hold_pol, cfg.ale_qual} = 4'hf;
    cfg.dual_phase = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      cfg.posted = i[0];
      cfg.bus16 = i < 8;
      cfg.indexed = (i == 9);
      big_endian = 1'($urandom);
      h.sel(1'b1);
      // Pass three skips both latch phases and must reuse the address.
      if (i != 3) begin
        hi = i[1] ? 8'($urandom) : 8'($urandom_range(31));
        lo = 8'($urandom);
        h.latch(hi, lo);
      end
      repeat (2) @(posedge clk);
      chk1(hold_oe, 1'b1);
      chk1(hold_out, 1'b0);
      n = n_acks;
      h.do_rd(v, ok);
      chk1(ok, 1'b1);
      chk1(n_acks != n, 1'b1);
      x = '0;
      x.addr = {hi, lo};
      x.be = cfg.bus16 ? HBP_BE_BOTH : (lo[0] ? HBP_BE_HI : HBP_BE_LO);
      chk_req(cap, x);
      e = {h_dh, lo[0] ? int_rdata[15:8] : int_rdata[7:0]};
      if (cfg.bus16) e = swap(int_rdata, big_endian);
      chk16(v, e);
      if (cfg.bus16) begin
        v = 16'($urandom);
        n = n_acks;
        h.do_wr(v, cfg.posted, ok);
        chk1(ok, 1'b1);
        for (int k = 0; k < 40 && n_acks == n; k++) @(negedge clk);
        x.write = 1'b1;
        x.data = swap(v, big_endian);
        chk_req(cap, x);
      end
      h.sel(1'b0);
    end
    give_verdict();
  end
endmodule : parallel_host_bus_port_bench
`default_nettype wire
